/* File: node_info_defs.vh */
`ifndef NODE_INFO_DEFS_VH
`define NODE_INFO_DEFS_VH

// identification and capability register byte offsets
`define OFS_CONTROLLER_TYPE     16'h0000
`define OFS_CONTROLLER_REVISION 16'h0001
`define OFS_BUILD_LO            16'h0002
`define OFS_BUILD_HI            16'h0003
`define OFS_MAPPING_UNIT_COUNT  16'h0004
`define OFS_SYNC_UNIT_COUNT     16'h0005
`define OFS_PROCESS_RAM_SIZE    16'h0006
`define OFS_PORT_DESCRIPTOR     16'h0007

// fixed capability values
`define RST_MAPPING_UNIT_COUNT  8'h08
`define RST_SYNC_UNIT_COUNT     8'h08
`define RST_PROCESS_RAM_SIZE    8'h08

// build register field positions
`define BUILD_MINOR_LSB         4
`define BUILD_MAINT_LSB         0

// port configuration codes and field positions
`define PORT_CFG_ABSENT         2'h0
`define PORT_CFG_UNCONF         2'h1
`define PORT_CFG_RSVD           2'h2
`define PORT_CFG_MII            2'h3
`define PORT0_LSB               0
`define PORT1_LSB               2
`define PORT2_LSB               4
`define PORT3_LSB               6

// address map
`define INFO_LAST               16'h0007
`define LMU_BASE                16'h0600
`define LMU_LAST                16'h067F
`define RSVD_A_BASE             16'h0680
`define RSVD_A_LAST             16'h06FF
`define SYNC_BASE               16'h0800
`define SYNC_LAST               16'h083F
`define RSVD_B_BASE             16'h0840
`define RSVD_B_LAST             16'h087F
`define DTU_BASE                16'h0900
`define DTU_LAST                16'h09FF
`define USER_BASE               16'h0F80
`define USER_LAST               16'h0FFF
`define PRAM_BASE               16'h1000
`define PRAM_LAST               16'h2FFF
`define DIGIN_BASE              16'h1000
`define DIGIN_LAST              16'h1003

// offsets within one mapping unit set (16 bytes)
`define LMU_OFS_LOG_START       4'h0
`define LMU_OFS_LENGTH          4'h4
`define LMU_OFS_START_BIT       4'h6
`define LMU_OFS_STOP_BIT        4'h7
`define LMU_OFS_PHYS_START      4'h8
`define LMU_OFS_PHYS_BIT        4'hA
`define LMU_OFS_TYPE            4'hB
`define LMU_OFS_ACTIVATE        4'hC

// offsets within one sync unit set (8 bytes)
`define SYNC_OFS_START          3'h0
`define SYNC_OFS_LENGTH         3'h2
`define SYNC_OFS_CONTROL        3'h4
`define SYNC_OFS_STATUS         3'h5
`define SYNC_OFS_ACTIVATE       3'h6
`define SYNC_OFS_LOCAL_CTRL     3'h7

// region codes
`define RGN_INFO                4'h0
`define RGN_LMU                 4'h1
`define RGN_SYNC                4'h2
`define RGN_DTU                 4'h3
`define RGN_USER                4'h4
`define RGN_PRAM                4'h5
`define RGN_DIGIN               4'h6
`define RGN_RSVD                4'h7
`define RGN_CORE                4'h8
`define RGN_NONE                4'h9

// field codes
`define FLD_NONE                4'h0
`define FLD_LOG_START           4'h1
`define FLD_LENGTH              4'h2
`define FLD_START_BIT           4'h3
`define FLD_STOP_BIT            4'h4
`define FLD_PHYS_START          4'h5
`define FLD_PHYS_BIT            4'h6
`define FLD_TYPE                4'h7
`define FLD_ACTIVATE            4'h8
`define FLD_CONTROL             4'h9
`define FLD_STATUS              4'hA
`define FLD_LOCAL_CTRL          4'hB
`define FLD_RSVD                4'hC

// host indirect command lengths in bytes
`define CMD_LEN_1               3'h1
`define CMD_LEN_2               3'h2
`define CMD_LEN_4               3'h4

`endif

/* File: csr_addr_decode.v */
`timescale 1ns/1ps
`include "node_info_defs.vh"

module csr_addr_decode (
   // address in
   input  wire [15:0] i_addr,
   input  wire        i_digio_mode,
   // decode out
   output reg  [3:0]  o_region,
   output reg  [2:0]  o_unit,
   output reg  [3:0]  o_field,
   output reg  [1:0]  o_fbyte
);

   always @* begin
      o_region = `RGN_NONE;
      o_unit   = 3'h0;
      o_field  = `FLD_NONE;
      o_fbyte  = 2'h0;
      if (i_addr <= `INFO_LAST) begin
         o_region = `RGN_INFO;
      end else if (i_addr >= `LMU_BASE && i_addr <= `LMU_LAST) begin
         o_region = `RGN_LMU;
         o_unit   = i_addr[6:4];
         if (i_addr[3:0] < `LMU_OFS_LENGTH) begin
            o_field = `FLD_LOG_START;
            o_fbyte = i_addr[1:0];
         end else if (i_addr[3:0] < `LMU_OFS_START_BIT) begin
            o_field = `FLD_LENGTH;
            o_fbyte = {1'b0, i_addr[0]};
         end else if (i_addr[3:0] == `LMU_OFS_START_BIT) begin
            o_field = `FLD_START_BIT;
         end else if (i_addr[3:0] == `LMU_OFS_STOP_BIT) begin
            o_field = `FLD_STOP_BIT;
         end else if (i_addr[3:0] < `LMU_OFS_PHYS_BIT) begin
            o_field = `FLD_PHYS_START;
            o_fbyte = {1'b0, i_addr[0]};
         end else if (i_addr[3:0] == `LMU_OFS_PHYS_BIT) begin
            o_field = `FLD_PHYS_BIT;
         end else if (i_addr[3:0] == `LMU_OFS_TYPE) begin
            o_field = `FLD_TYPE;
         end else if (i_addr[3:0] == `LMU_OFS_ACTIVATE) begin
            o_field = `FLD_ACTIVATE;
         end else begin
            o_field = `FLD_RSVD;
         end
      end else if (i_addr >= `RSVD_A_BASE && i_addr <= `RSVD_A_LAST) begin
         o_region = `RGN_RSVD;
      end else if (i_addr >= `SYNC_BASE && i_addr <= `SYNC_LAST) begin
         o_region = `RGN_SYNC;
         o_unit   = i_addr[5:3];
         case (i_addr[2:0])
            `SYNC_OFS_START, 3'h1: begin
               o_field = `FLD_PHYS_START;
               o_fbyte = {1'b0, i_addr[0]};
            end
            `SYNC_OFS_LENGTH, 3'h3: begin
               o_field = `FLD_LENGTH;
               o_fbyte = {1'b0, i_addr[0]};
            end
            `SYNC_OFS_CONTROL:    o_field = `FLD_CONTROL;
            `SYNC_OFS_STATUS:     o_field = `FLD_STATUS;
            `SYNC_OFS_ACTIVATE:   o_field = `FLD_ACTIVATE;
            `SYNC_OFS_LOCAL_CTRL: o_field = `FLD_LOCAL_CTRL;
            default:              o_field = `FLD_NONE;
         endcase
      end else if (i_addr >= `RSVD_B_BASE && i_addr <= `RSVD_B_LAST) begin
         o_region = `RGN_RSVD;
      end else if (i_addr >= `DTU_BASE && i_addr <= `DTU_LAST) begin
         o_region = `RGN_DTU;
      end else if (i_addr >= `USER_BASE && i_addr <= `USER_LAST) begin
         o_region = `RGN_USER;
      end else if (i_digio_mode && i_addr >= `DIGIN_BASE && i_addr <= `DIGIN_LAST) begin
         o_region = `RGN_DIGIN;
         o_fbyte  = i_addr[1:0];
      end else if (i_addr >= `PRAM_BASE && i_addr <= `PRAM_LAST) begin
         o_region = `RGN_PRAM;
      end else if (i_addr < `PRAM_BASE) begin
         o_region = `RGN_CORE;
      end
   end

endmodule

/* File: node_info_and_csr_map.v */
`timescale 1ns/1ps
`include "node_info_defs.vh"

module node_info_and_csr_map #(
   parameter [7:0] TYPE_CODE  = 8'h5A, // arbitrary neutral value
   parameter [7:0] REV_CODE   = 8'h01, // arbitrary neutral value
   parameter [3:0] BUILD_MINOR = 4'h0,
   parameter [3:0] BUILD_MAINT = 4'h0
) (
   // clock and reset
   input  wire        i_core_clk,
   input  wire        i_rstn,
   // straps and mode
   input  wire        i_three_port_strap,
   input  wire        i_digio_mode,
   input  wire [31:0] i_digio_in,
   // network side byte access
   input  wire        i_net_req,
   input  wire        i_net_wr,
   input  wire [15:0] i_net_addr,
   input  wire [7:0]  i_net_wdata,
   output reg  [7:0]  o_net_rdata,
   output reg         o_net_ack,
   // local host port indirect access
   input  wire        i_host_cmd_wr,
   input  wire [15:0] i_host_cmd_addr,
   input  wire [2:0]  i_host_cmd_len,
   input  wire        i_host_cmd_rnw,
   input  wire        i_host_data_wr,
   input  wire [31:0] i_host_data_wdata,
   output reg  [31:0] o_host_data_rdata,
   output wire        o_host_busy,
   // core register and RAM access toward the rest of the core
   output wire        o_ext_rd,
   output wire        o_ext_wr,
   output wire [15:0] o_ext_addr,
   output wire [7:0]  o_ext_wdata,
   output wire [3:0]  o_ext_region,
   output wire [2:0]  o_ext_unit,
   output wire [3:0]  o_ext_field,
   output wire [1:0]  o_ext_fbyte,
   input  wire [7:0]  i_ext_rdata
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN  = 1'b1;

   ////////////////////////////////////////////////////////////////////////////////
   // strap capture

   // caught on the first edge after release, never by the reset itself
   reg        strap_done_q;
   reg        three_port_q;

   always @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         strap_done_q <= 1'b0;
         three_port_q <= 1'b0;
      end else if (!strap_done_q) begin
         strap_done_q <= 1'b1;
         three_port_q <= i_three_port_strap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // identification values

   wire [15:0] build_word;
   wire [1:0]  port2_cfg;
   wire [7:0]  port_desc;

   assign build_word = {8'h00, BUILD_MINOR, BUILD_MAINT};
   assign port2_cfg  = three_port_q ? `PORT_CFG_MII : `PORT_CFG_UNCONF;
   assign port_desc  = {`PORT_CFG_ABSENT,
                        port2_cfg,
                        `PORT_CFG_MII,
                        `PORT_CFG_MII};

   ////////////////////////////////////////////////////////////////////////////////
   // host indirect engine state

   reg         state_q;
   reg         state_d;
   reg  [15:0] haddr_q;
   reg  [2:0]  hlen_q;
   reg  [2:0]  hcnt_q;
   reg  [2:0]  hcnt_d;
   reg         hrnw_q;
   reg  [31:0] hdata_q;
   reg  [31:0] hdata_d;
   wire        cmd_ok;
   wire        host_slot;
   wire [15:0] host_byte_addr;
   wire [7:0]  host_wbyte;

   assign cmd_ok = (i_host_cmd_len == `CMD_LEN_1) ||
                   (i_host_cmd_len == `CMD_LEN_2) ||
                   (i_host_cmd_len == `CMD_LEN_4);

   // network side wins every cycle it asks; host bytes use idle cycles
   assign host_slot      = (state_q == ST_RUN) && !i_net_req;
   assign host_byte_addr = haddr_q + {13'h0000, hcnt_q};
   assign host_wbyte     = hdata_q[{hcnt_q[1:0], 3'b000} +: 8];
   assign o_host_busy    = (state_q == ST_RUN);

   ////////////////////////////////////////////////////////////////////////////////
   // shared access selection and decode

   wire        acc;
   wire        acc_wr;
   wire [15:0] acc_addr;
   wire [7:0]  acc_wdata;
   wire [3:0]  region;
   wire [2:0]  unit;
   wire [3:0]  field;
   wire [1:0]  fbyte;
   wire        forward;

   assign acc       = i_net_req || host_slot;
   assign acc_wr    = i_net_req ? i_net_wr : !hrnw_q;
   assign acc_addr  = i_net_req ? i_net_addr : host_byte_addr;
   assign acc_wdata = i_net_req ? i_net_wdata : host_wbyte;

   csr_addr_decode u_decode (
      .i_addr       (acc_addr),
      .i_digio_mode (i_digio_mode),
      .o_region     (region),
      .o_unit       (unit),
      .o_field      (field),
      .o_fbyte      (fbyte)
   );

   // info, overlay and reserved bytes are answered here and never forwarded
   assign forward = (region != `RGN_INFO) && (region != `RGN_DIGIN) &&
                    (region != `RGN_RSVD) && (region != `RGN_NONE);

   assign o_ext_rd     = acc && !acc_wr && forward;
   assign o_ext_wr     = acc && acc_wr && forward;
   assign o_ext_addr   = acc_addr;
   assign o_ext_wdata  = acc_wdata;
   assign o_ext_region = region;
   assign o_ext_unit   = unit;
   assign o_ext_field  = field;
   assign o_ext_fbyte  = fbyte;

   ////////////////////////////////////////////////////////////////////////////////
   // read byte mux

   reg [7:0] rd_byte;

   always @* begin
      rd_byte = 8'h00;
      case (region)
         `RGN_INFO: begin
            case (acc_addr[2:0])
               3'h0:    rd_byte = TYPE_CODE;
               3'h1:    rd_byte = REV_CODE;
               3'h2:    rd_byte = build_word[7:0];
               3'h3:    rd_byte = build_word[15:8];
               3'h4:    rd_byte = `RST_MAPPING_UNIT_COUNT;
               3'h5:    rd_byte = `RST_SYNC_UNIT_COUNT;
               3'h6:    rd_byte = `RST_PROCESS_RAM_SIZE;
               3'h7:    rd_byte = port_desc;
               default: rd_byte = 8'h00;
            endcase
         end
         `RGN_DIGIN: rd_byte = i_digio_in[{fbyte, 3'b000} +: 8];
         `RGN_RSVD:  rd_byte = 8'h00;
         `RGN_NONE:  rd_byte = 8'h00;
         default:    rd_byte = i_ext_rdata;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////////
   // network side answer

   // one byte per request, answered on the following edge
   always @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         o_net_ack   <= 1'b0;
         o_net_rdata <= 8'h00;
      end else begin
         o_net_ack <= i_net_req;
         if (i_net_req && !i_net_wr) begin
            o_net_rdata <= rd_byte;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // host indirect engine

   always @* begin
      state_d = state_q;
      hcnt_d  = hcnt_q;
      hdata_d = hdata_q;
      case (state_q)
         ST_IDLE: begin
            if (i_host_data_wr) begin
               hdata_d = i_host_data_wdata;
            end
            if (i_host_cmd_wr && cmd_ok) begin
               state_d = ST_RUN;
               hcnt_d  = 3'h0;
               if (i_host_cmd_rnw) begin
                  hdata_d = 32'h00000000;
               end
            end
         end
         ST_RUN: begin
            // command and data writes while busy are dropped
            if (host_slot) begin
               if (hrnw_q) begin
                  hdata_d[{hcnt_q[1:0], 3'b000} +: 8] = rd_byte;
               end
               hcnt_d = hcnt_q + 3'h1;
               if (hcnt_q + 3'h1 == hlen_q) begin
                  state_d = ST_IDLE;
               end
            end
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge i_core_clk or negedge i_rstn) begin
      if (!i_rstn) begin
         state_q <= ST_IDLE;
         haddr_q <= 16'h0000;
         hlen_q  <= 3'h0;
         hcnt_q  <= 3'h0;
         hrnw_q  <= 1'b1;
         hdata_q <= 32'h00000000;
      end else begin
         state_q <= state_d;
         hcnt_q  <= hcnt_d;
         hdata_q <= hdata_d;
         if (state_q == ST_IDLE && i_host_cmd_wr && cmd_ok) begin
            haddr_q <= i_host_cmd_addr;
            hlen_q  <= i_host_cmd_len;
            hrnw_q  <= i_host_cmd_rnw;
         end
      end
   end

   always @* begin
      o_host_data_rdata = hdata_q;
   end

endmodule

/* File: node_info_monitor.sv */
`timescale 1ns/1ps
module node_info_monitor #(
   parameter [3:0] BUILD_MINOR = 4'h0,
   parameter [3:0] BUILD_MAINT = 4'h0
) (
   input wire        i_core_clk,
   input wire        i_rstn,
   input wire        i_three_port_strap,
   input wire        i_digio_mode,
   input wire [31:0] i_digio_in,
   input wire        i_net_req,
   input wire        i_net_wr,
   input wire [15:0] i_net_addr,
   input wire [7:0]  o_net_rdata,
   input wire        i_host_cmd_wr,
   input wire [2:0]  i_host_cmd_len,
   input wire        o_host_busy,
   input wire        o_ext_rd,
   input wire        o_ext_wr,
   input wire [3:0]  o_ext_region,
   input wire [2:0]  o_ext_unit,
   input wire [3:0]  o_ext_field,
   input wire [7:0]  i_ext_rdata
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rstn);
   ////////////////////////////////////////////////////////////////
   wire [15:0] a      = i_net_addr;
   wire        rd     = i_net_req && !i_net_wr;
   wire        rsvd   = (a >= 16'h0680 && a <= 16'h06FF) || (a >= 16'h0840 && a <= 16'h087F);
   wire [7:0]  desc_x = {2'b00, i_three_port_strap ? 2'b11 : 2'b01, 4'hF};
   wire [7:0]  bld_x  = a[0] ? 8'h00 : {BUILD_MINOR, BUILD_MAINT};
   wire [7:0]  din_b  = i_digio_in[{a[1:0], 3'b000} +: 8];
   sequence host_go;
      i_host_cmd_wr && !o_host_busy && (i_host_cmd_len == 3'h1 || i_host_cmd_len == 3'h2 || i_host_cmd_len == 3'h4);
   endsequence
   // bound holds only while the network side stays quiet
   sequence host_done;
      o_host_busy ##[1:8] !o_host_busy;
   endsequence
   sequence pram_rd;
      rd && a >= 16'h1004 && a <= 16'h2FFF;
   endsequence
   ////////////////////////////////////////////////////////////////
   a_desc_value: assert property (rd && a == 16'h0007 |=> o_net_rdata == $past(desc_x))
      else $error("port descriptor wrong");
   a_count_value: assert property (rd && a >= 16'h0004 && a <= 16'h0006 |=> o_net_rdata == 8'h08)
      else $error("capability count wrong");
   a_build_bytes: assert property (rd && a[15:1] == 15'h0001 |=> o_net_rdata == $past(bld_x))
      else $error("build byte wrong");
   a_ro_no_fwd: assert property (i_net_req && i_net_wr && (a <= 16'h0007 || rsvd) |-> !o_ext_wr)
      else $error("protected write forwarded");
   a_rsvd_zero: assert property (rd && rsvd |=> o_net_rdata == 8'h00)
      else $error("reserved read not zero");
   a_lmu_field: assert property (i_net_req && a[15:7] == 9'h00C && a[3:0] == 4'hB |->
      o_ext_region == 4'h1 && o_ext_field == 4'h7 && o_ext_unit == a[6:4]) else $error("mapping decode wrong");
   a_sync_field: assert property (i_net_req && a[15:6] == 10'h020 && a[2:0] == 3'h4 |->
      o_ext_region == 4'h2 && o_ext_field == 4'h9 && o_ext_unit == a[5:3]) else $error("sync decode wrong");
   a_pram_path: assert property (pram_rd |-> o_ext_rd && o_ext_region == 4'h5 ##1
      o_net_rdata == $past(i_ext_rdata)) else $error("process RAM read wrong");
   a_digin_byte: assert property (i_digio_mode && rd && a[15:2] == 14'h0400 |=> o_net_rdata == $past(din_b))
      else $error("digital input byte wrong");
   a_host_run: assert property (host_go |=> host_done)
      else $error("host command did not finish");
endmodule

bind node_info_and_csr_map node_info_monitor #(.BUILD_MINOR(BUILD_MINOR), .BUILD_MAINT(BUILD_MAINT)) u_mon (
   .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_three_port_strap(i_three_port_strap),
   .i_digio_mode(i_digio_mode), .i_digio_in(i_digio_in), .i_net_req(i_net_req), .i_net_wr(i_net_wr),
   .i_net_addr(i_net_addr), .o_net_rdata(o_net_rdata), .i_host_cmd_wr(i_host_cmd_wr),
   .i_host_cmd_len(i_host_cmd_len), .o_host_busy(o_host_busy), .o_ext_rd(o_ext_rd), .o_ext_wr(o_ext_wr),
   .o_ext_region(o_ext_region), .o_ext_unit(o_ext_unit), .o_ext_field(o_ext_field), .i_ext_rdata(i_ext_rdata));

/* File: core_rest_model.sv */
`timescale 1ns/1ps
module core_rest_model (
   input  wire        i_core_clk,
   input  wire        i_rd,
   input  wire        i_wr,
   input  wire [15:0] i_addr,
   input  wire [7:0]  i_wdata,
   output reg  [7:0]  o_rdata
);
   reg [7:0] mem [0:16383];
   reg [7:0] last_q;
   integer   i;
   initial begin
      last_q = 8'h00;
      for (i = 0; i < 16384; i = i + 1)
         mem[i] = i[7:0] ^ 8'h5A;
   end
   // idle bus shows inverse of last byte, so a stale copy never passes
   always @*
      o_rdata = i_rd ? mem[i_addr[13:0]] : ~last_q;
   always @(posedge i_core_clk) begin
      if (i_wr)
         mem[i_addr[13:0]] <= i_wdata;
      if (i_rd)
         last_q <= mem[i_addr[13:0]];
   end
endmodule

/* File: node_info_and_csr_map_bench.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared = n_compared + 1; if ((g) !== (e)) begin fails = fails + 1; \
   $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module node_info_and_csr_map_bench;
   localparam [7:0] TYPE_V = 8'h6B; // arbitrary
   localparam [7:0] REV_V  = 8'h02; // arbitrary
   localparam [7:0] BLD_V  = 8'h39;
   reg         clk = 0, rstn = 0, strap = 1, dmode = 0, req = 0, wr = 0, cw = 0, crnw = 0, dw = 0;
   reg  [31:0] din = 32'h8A4B2C1D, dwd = 0;
   reg  [15:0] addr = 0, ca = 0;
   reg  [7:0]  wd = 0, r;
   reg  [2:0]  cl = 1, g_unit;
   reg  [3:0]  g_rgn, g_fld;
   reg         g_ewr, g_ack;
   reg  [1:0]  g_fb;
   wire [7:0]  rd, ewd, erdata;
   wire [31:0] hrd;
   wire [15:0] ea;
   wire [3:0]  ergn, efld;
   wire [2:0]  eunit;
   wire [1:0]  efb;
   wire        ack, busy, erd, ewr;
   integer     fails = 0, n_compared = 0, cyc = 0, i, k, n_ewr = 0;
   node_info_and_csr_map #(.TYPE_CODE(TYPE_V), .REV_CODE(REV_V),
      .BUILD_MINOR(BLD_V[7:4]), .BUILD_MAINT(BLD_V[3:0])) DUT (
      .i_core_clk(clk), .i_rstn(rstn), .i_three_port_strap(strap), .i_digio_mode(dmode), .i_digio_in(din),
      .i_net_req(req), .i_net_wr(wr), .i_net_addr(addr), .i_net_wdata(wd), .o_net_rdata(rd), .o_net_ack(ack),
      .i_host_cmd_wr(cw), .i_host_cmd_addr(ca), .i_host_cmd_len(cl), .i_host_cmd_rnw(crnw), .i_host_data_wr(dw),
      .i_host_data_wdata(dwd), .o_host_data_rdata(hrd), .o_host_busy(busy), .o_ext_rd(erd), .o_ext_wr(ewr),
      .o_ext_addr(ea), .o_ext_wdata(ewd), .o_ext_region(ergn), .o_ext_unit(eunit), .o_ext_field(efld),
      .o_ext_fbyte(efb), .i_ext_rdata(erdata));
   core_rest_model u_core (.i_core_clk(clk), .i_rd(erd), .i_wr(ewr), .i_addr(ea), .i_wdata(ewd), .o_rdata(erdata));
   ////////////////////////////////////////////////////////////////
   always #10 clk = ~clk;
   // counted mid-cycle, where the write strobe has settled
   always @(negedge clk)
      if (ewr)
         n_ewr = n_ewr + 1;
   always @(posedge clk) begin
      cyc = cyc + 1;
      if (cyc == 6000) begin
         fails = fails + 1;
         finish_test;
      end
   end
   function [7:0] info_v(input [2:0] n);
      case (n)
         3'h0: info_v = TYPE_V;
         3'h1: info_v = REV_V;
         3'h2: info_v = BLD_V;
         3'h3: info_v = 8'h00;
         3'h7: info_v = {2'b00, strap ? 2'b11 : 2'b01, 2'b11, 2'b11};
         default: info_v = 8'h08;
      endcase
   endfunction
   task do_reset(input s);
      begin
         rstn = 0;
         strap = s;
         repeat (3) @(posedge clk);
         #1 rstn = 1;
         repeat (2) @(posedge clk);
      end
   endtask
   task net(input w, input [15:0] a, input [7:0] d);
      begin
         @(posedge clk);
         #1 {req, wr, addr, wd} = {1'b1, w, a, d};
         #1 {g_rgn, g_fld, g_unit, g_ewr, g_fb} = {ergn, efld, eunit, ewr, efb};
         @(posedge clk);
         #1 {req, wr} = 2'b00;
         r = rd;
         g_ack = ack;
      end
   endtask
   task host(input [15:0] a, input [2:0] l, input rn, input [31:0] d);
      begin
         @(posedge clk);
         #1 {cw, ca, cl, crnw, dw, dwd} = {1'b1, a, l, rn, !rn, d};
         @(posedge clk);
         #1 {cw, dw} = 2'b00;
         `CHK(busy, 1'b1)
         @(posedge clk);
         #1 k = 0;
         while (busy !== 1'b0 && k < 20) begin
            @(posedge clk);
            #1 k = k + 1;
         end
         `CHK(busy, 1'b0)
      end
   endtask
   ////////////////////////////////////////////////////////////////
   task t_info;
      for (i = 0; i < 8; i = i + 1) begin
         net(0, i, 0);
         `CHK(r, info_v(i))
         net(1, i, 8'hFF);
         `CHK({g_ewr, g_ack}, 2'b01)
         net(0, i, 0);
         `CHK(r, info_v(i))
      end
   endtask
   task t_host;
      begin
         host(16'h0004, 3'h4, 0, 32'hFFFFFFFF);
         `CHK(n_ewr, 0)
         host(16'h0004, 3'h4, 1, 0);
         `CHK(hrd, {info_v(7), 24'h080808})
         host(16'h0002, 3'h2, 1, 0);
         `CHK(hrd, {24'h0, BLD_V})
         host(16'h0007, 3'h1, 1, 0);
         `CHK(hrd, {24'h0, info_v(7)})
         host(16'h0F90, 3'h4, 0, 32'hA5C3E1F0);
         host(16'h0F90, 3'h4, 1, 0);
         `CHK(hrd, 32'hA5C3E1F0)
      end
   endtask
   task t_map;
      begin
         for (i = 0; i < 4; i = i + 1) begin
            net(1, (i < 2) ? 16'h0680 + 127 * i : 16'h0840 + 63 * (i - 2), 8'h5C);
            `CHK(g_ewr, 1'b0)
            net(0, addr, 0);
            `CHK(r, 8'h00)
         end
         net(1, 16'h0F80, 8'hA1);
         net(1, 16'h0FFF, 8'hA2);
         net(0, 16'h0F80, 0);
         `CHK(r, 8'hA1)
         net(0, 16'h0FFF, 0);
         `CHK(r, 8'hA2)
         net(1, 16'h1000, 8'h71);
         net(1, 16'h2FFF, 8'h72);
         net(0, 16'h2FFF, 0);
         `CHK(r, 8'h72)
         net(0, 16'h3000, 0);
         `CHK(r, 8'h00)
      end
   endtask
   task t_digio;
      begin
         @(posedge clk);
         #1 dmode = 1;
         for (i = 0; i < 4; i = i + 1) begin
            net(0, 16'h1000 + i, 0);
            `CHK(r, din[8 * i +: 8])
            `CHK(g_fb, i[1:0])
         end
         net(1, 16'h1000, 8'hEE);
         `CHK(g_ewr, 1'b0)
         @(posedge clk);
         #1 dmode = 0;
         net(0, 16'h1000, 0);
         `CHK(r, 8'h71)
      end
   endtask
   task t_decode;
      for (i = 0; i < 8; i = i + 1)
         for (k = 0; k < 4; k = k + 1) begin
            net(0, 16'h0600 + 16 * i + ((16'hCBA8 >> 4 * k) & 15), 0);
            `CHK({g_rgn, g_unit, g_fld}, {4'h1, i[2:0], 4'h5 + k[3:0]})
            net(0, 16'h0804 + 8 * i + k, 0);
            `CHK({g_rgn, g_unit, g_fld}, {4'h2, i[2:0], 4'((16'hB8A9 >> 4 * k) & 15)})
         end
   endtask
   task finish_test;
      begin
         $display("compared=%0d fails=%0d", n_compared, fails);
         if (fails == 0 && n_compared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   initial begin
      do_reset(1);
      t_info;
      t_host;
      t_map;
      t_digio;
      t_decode;
      do_reset(0);
      net(0, 16'h0007, 0);
      `CHK(r, 8'h1F)
      finish_test;
   end
endmodule
